// *** hw/cpm_pkg.sv ***
package cpm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CFG_FIRST = 8'h04; // module_control_one, then bit timing, acceptance
  localparam logic [7:0] OFS_CFG_LAST = 8'h30;
  localparam logic [7:0] OFS_ERR_CNT = 8'h34;
  localparam logic [7:0] OFS_RX_FLAGS = 8'h38;
  localparam logic [7:0] OFS_TX_FLAGS = 8'h3c;
  localparam int CFG_WORDS = 12;
  // control register zero bit positions
  localparam int B_SOFT_RESET = 0;
  localparam int B_SLEEP_REQ = 1;
  localparam int B_SLEEP_ACK = 2;
  localparam int B_TLINK_EN = 3;
  localparam int B_WUP_IE = 4;
  localparam int B_WUP_IF = 5;
  localparam int B_JOINED = 6;
  // module_control_one bit position
  localparam int B_WUP_FILTER = 0;
  // values after reset
  localparam logic RST_SOFT_RESET = 1'b1;
  localparam logic RST_SLEEP_REQ = 1'b0;
  localparam logic [7:0] RST_CFG = 8'h00;
  // counts
  localparam logic [3:0] RESYNC_BITS = 4'd11;
  localparam int BIT_CYCLES_DEF = 100; // one bit at 1 Mbit/s and 100 MHz
  localparam int FILT_CYCLES_DEF = 32;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {CPM_NORMAL, CPM_SLEEP, CPM_SOFT_RESET, CPM_POWER_DOWN} cpm_mode_t;
endpackage

// *** hw/cpm_sync.sv ***
`timescale 1ns/1ps
module cpm_sync import cpm_pkg::*; #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic din,
  output logic dout
);
  logic meta_q;
  logic sync_q;
  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end
  assign dout = sync_q;
endmodule // cpm_sync

// *** hw/cpm_wake_filter.sv ***
`timescale 1ns/1ps
module cpm_wake_filter import cpm_pkg::*; #(
  parameter int FILT_CYCLES = FILT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic enable,
  input wire logic rx,
  output logic dominant
);
  localparam int CW = $clog2(FILT_CYCLES + 1);
  localparam logic [CW-1:0] FILT_MAX = CW'(FILT_CYCLES);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  // count consecutive dominant samples, any recessive sample restarts
  assign cnt_d = rx ? '0 : ((cnt_q == FILT_MAX) ? cnt_q : cnt_q + CW'(1));
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // with enable set only a long enough dominant level counts; with enable clear any dominant rx sample does
  assign dominant = enable ? (cnt_q == FILT_MAX) : !rx;
endmodule // cpm_wake_filter

// *** hw/cpm_top.sv ***
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - error counters are read-only; software writes to them have no effect
// - configuration registers accept writes only while soft reset is set
// - transmit pin held recessive in sleep, soft reset and power-down
// - mode: cpu stopped is power-down, else sleep/soft reset/normal from bits
// - wakeup interrupt only when sleep acknowledge and wakeup enable both set
// - sleep entered when idle, after current reception, after all queued transmits
// - sleep acknowledge set exactly while asleep, polled by software
// - sleep stops protocol clocks and bus-off recovery count, registers stay usable
// - asleep: buffers usable, flags clearable, no buffer copy, no aborts
// - wake on bus activity, sleep request cleared, or soft reset set
// - sleep request cannot be cleared before sleep acknowledge is set
// - after waking wait eleven recessive bits before joining the bus
// - on wakeup deferred copy, aborts, transmits and recovery count resume
// - soft reset halts all traffic at once, registers remain accessible
// - power-down aborts traffic, stops clocks, refuses register access
// - bus activity in power-down wakes cpu; no reception until resynchronised
// - cpu wait keeps block running; enabled interrupts end the wait
// - wakeup filter select low-pass filters receive input during sleep
// - one bit time timer pulse after every valid frame end
// - timer pulse reaches capture channel zero only with timer link enabled
// - flags clear on write of one, stay set while their cause persists
module cpm_top import cpm_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF,
  parameter int FILT_CYCLES = FILT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // CAN pins
  input wire logic can_rx,
  output logic can_tx,
  // cpu state
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  output logic cpu_wake,
  // protocol engine side
  input wire logic core_tx_bit,
  input wire logic core_rx_busy,
  input wire logic core_tx_busy,
  input wire logic core_tx_pending,
  input wire logic core_bit_tick,
  input wire logic core_frame_ok,
  input wire logic core_irq,
  input wire logic [7:0] core_rx_err_cnt,
  input wire logic [7:0] core_tx_err_cnt,
  input wire logic [7:0] core_rx_flag_set,
  input wire logic [2:0] core_tx_empty_set,
  output logic core_clk_en,
  output logic core_halt,
  output logic core_joined,
  output logic core_copy_en,
  output logic core_abort_en,
  output logic core_tx_en,
  output logic core_recover_en,
  output logic [7:0] cfg_module_one,
  output logic [15:0] cfg_bit_timing,
  output logic [7:0] cfg_accept_ctrl,
  output logic [31:0] cfg_accept_codes,
  output logic [31:0] cfg_accept_masks,
  output logic [7:0] receiver_flags,
  output logic [2:0] transmit_empty_flag,
  output logic wakeup_irq,
  output logic timer_capture0
);
  localparam int TW = $clog2(BIT_CYCLES + 1);
  localparam logic [TW-1:0] BIT_LEN = TW'(BIT_CYCLES);

  // map a byte address to a register class
  function automatic logic [3:0] reg_sel(input logic [7:0] a);
    if (a == OFS_CTRL0) reg_sel = 4'h1;
    else if (a >= OFS_CFG_FIRST && a <= OFS_CFG_LAST && a[1:0] == 2'b00) reg_sel = 4'h2;
    else if (a == OFS_ERR_CNT) reg_sel = 4'h3;
    else if (a == OFS_RX_FLAGS) reg_sel = 4'h4;
    else if (a == OFS_TX_FLAGS) reg_sel = 4'h5;
    else reg_sel = 4'h0;
  endfunction

  logic soft_reset_request_q;
  logic sleep_request_q;
  logic sleep_acknowledge_q;
  logic timer_link_enable_q;
  logic wakeup_irq_enable_q;
  logic wakeup_irq_flag_q;
  logic joined_q;
  logic [3:0] resync_cnt_q;
  logic [7:0] cfg_q [CFG_WORDS];
  logic [7:0] rx_flags_q;
  logic [2:0] tx_flags_q;
  logic [TW-1:0] pulse_cnt_q;
  logic aw_held_q;
  logic w_held_q;
  logic [7:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  cpm_mode_t mode;

  // receive pin synchronised and filtered for wakeup
  logic rx_s;
  logic rx_wake_dom;
  cpm_sync #(.RST_VAL(1'b1)) u_rx_sync (
    .clk(clk),
    .arst_n(arst_n),
    .din(can_rx),
    .dout(rx_s)
  );
  cpm_wake_filter #(.FILT_CYCLES(FILT_CYCLES)) u_filter (
    .clk(clk),
    .arst_n(arst_n),
    .enable(cfg_q[0][B_WUP_FILTER]),
    .rx(rx_s),
    .dominant(rx_wake_dom)
  );

  // operating mode decode
  assign mode = cpu_stop ? CPM_POWER_DOWN
              : (soft_reset_request_q ? CPM_SOFT_RESET
              : (sleep_acknowledge_q ? CPM_SLEEP : CPM_NORMAL));
  wire running = (mode == CPM_NORMAL); // also during cpu wait
  wire bus_wake = sleep_acknowledge_q && rx_wake_dom;
  wire idle_for_sleep = !core_rx_busy && !core_tx_busy && !core_tx_pending;

  // AXI write channel decode
  wire aw_take = s_axi_awvalid && !aw_held_q && !bvalid_q;
  wire w_take = s_axi_wvalid && !w_held_q && !bvalid_q;
  wire aw_have = aw_held_q || aw_take;
  wire w_have = w_held_q || w_take;
  wire wr_fire = aw_have && w_have && !bvalid_q;
  wire [7:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [7:0] wr_data = w_held_q ? wdata_q : s_axi_wdata[7:0];
  wire wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
  wire [3:0] wr_sel = reg_sel(wr_addr);
  wire wr_ok = wr_fire && (mode != CPM_POWER_DOWN) && (wr_sel != 4'h0);
  wire wr_en = wr_ok && wr_lane0;
  wire [3:0] wr_cfg_idx = 4'(wr_addr[7:2] - 6'd1);
  wire wr_ctrl0 = wr_en && (wr_sel == 4'h1);
  wire wr_cfg = wr_en && (wr_sel == 4'h2) && soft_reset_request_q;
  wire wr_rxf = wr_en && (wr_sel == 4'h4);
  wire wr_txf = wr_en && (wr_sel == 4'h5);
  // writes to the error counter offset are answered but change nothing

  // AXI read channel decode
  wire ar_take = s_axi_arvalid && !rvalid_q;
  wire [3:0] rd_sel = reg_sel(s_axi_araddr);
  wire rd_ok = (mode != CPM_POWER_DOWN) && (rd_sel != 4'h0);
  wire [3:0] rd_cfg_idx = 4'(s_axi_araddr[7:2] - 6'd1);

  // control register zero next values
  wire soft_reset_d = wr_ctrl0 ? wr_data[B_SOFT_RESET] : soft_reset_request_q;
  wire srst_rise = soft_reset_d && !soft_reset_request_q;
  wire sleep_clear_wr = wr_ctrl0 && !wr_data[B_SLEEP_REQ];
  // clearing is refused until acknowledged
  wire sleep_req_wr = !wr_ctrl0 ? sleep_request_q
                    : (wr_data[B_SLEEP_REQ] || (sleep_request_q && !sleep_acknowledge_q));
  wire wake_event = sleep_acknowledge_q &&
                    (bus_wake || (sleep_clear_wr && sleep_request_q) || srst_rise);
  // bus wakeup also drops the request so the block stays awake
  wire sleep_request_d = (bus_wake && sleep_acknowledge_q) ? 1'b0 : sleep_req_wr;
  wire enter_sleep = sleep_request_q && !sleep_acknowledge_q && idle_for_sleep &&
                     !soft_reset_request_q && !srst_rise && !cpu_stop;
  wire sleep_ack_d = wake_event ? 1'b0 : (enter_sleep ? 1'b1 : sleep_acknowledge_q);
  wire wup_set = bus_wake && wakeup_irq_enable_q;
  wire wup_clr = wr_ctrl0 && wr_data[B_WUP_IF];
  wire wup_flag_d = wup_set || (wakeup_irq_flag_q && !wup_clr); // set wins over clear

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      soft_reset_request_q <= RST_SOFT_RESET;
      sleep_request_q <= RST_SLEEP_REQ;
      sleep_acknowledge_q <= 1'b0;
      timer_link_enable_q <= 1'b0;
      wakeup_irq_enable_q <= 1'b0;
      wakeup_irq_flag_q <= 1'b0;
    end else begin
      soft_reset_request_q <= soft_reset_d;
      sleep_request_q <= sleep_request_d;
      sleep_acknowledge_q <= sleep_ack_d;
      timer_link_enable_q <= wr_ctrl0 ? wr_data[B_TLINK_EN] : timer_link_enable_q;
      wakeup_irq_enable_q <= wr_ctrl0 ? wr_data[B_WUP_IE] : wakeup_irq_enable_q;
      wakeup_irq_flag_q <= wup_flag_d;
    end
  end

  // locked configuration bytes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < CFG_WORDS; i++) begin
        cfg_q[i] <= RST_CFG;
      end
    end else if (wr_cfg) begin
      cfg_q[wr_cfg_idx] <= wr_data;
    end
  end

  // receiver and transmitter flags, clear by writing one, cause keeps them set
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_flags_q <= 8'h00;
      tx_flags_q <= 3'h0;
    end else begin
      rx_flags_q <= core_rx_flag_set | (rx_flags_q & ~(wr_rxf ? wr_data : 8'h00));
      tx_flags_q <= core_tx_empty_set | (tx_flags_q & ~(wr_txf ? wr_data[2:0] : 3'h0));
    end
  end

  // resynchronisation: eleven recessive bits before joining
  wire resync_rst = !running || wake_event;
  wire resync_hit = core_bit_tick && rx_s && (resync_cnt_q == RESYNC_BITS - 4'd1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      resync_cnt_q <= 4'd0;
      joined_q <= 1'b0;
    end else if (resync_rst) begin
      resync_cnt_q <= 4'd0;
      joined_q <= 1'b0;
    end else if (!joined_q && core_bit_tick) begin
      resync_cnt_q <= rx_s ? resync_cnt_q + 4'd1 : 4'd0;
      joined_q <= resync_hit;
    end
  end

  // one bit time pulse after each valid frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pulse_cnt_q <= '0;
    end else if (core_frame_ok && running) begin
      pulse_cnt_q <= BIT_LEN;
    end else if (pulse_cnt_q != '0) begin
      pulse_cnt_q <= pulse_cnt_q - TW'(1);
    end
  end

  // AXI write handshake state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (aw_take) awaddr_q <= s_axi_awaddr;
      if (w_take) wdata_q <= s_axi_wdata[7:0];
      if (w_take) wstrb0_q <= s_axi_wstrb[0];
      aw_held_q <= aw_have && !wr_fire;
      w_held_q <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // read data mux
  logic [31:0] rd_word;
  always_comb begin
    rd_word = 32'h0000_0000;
    case (rd_sel)
      4'h1: begin
        rd_word[B_SOFT_RESET] = soft_reset_request_q;
        rd_word[B_SLEEP_REQ] = sleep_request_q;
        rd_word[B_SLEEP_ACK] = sleep_acknowledge_q;
        rd_word[B_TLINK_EN] = timer_link_enable_q;
        rd_word[B_WUP_IE] = wakeup_irq_enable_q;
        rd_word[B_WUP_IF] = wakeup_irq_flag_q;
        rd_word[B_JOINED] = joined_q;
      end
      4'h2: rd_word[7:0] = cfg_q[rd_cfg_idx];
      4'h3: rd_word[15:0] = {core_tx_err_cnt, core_rx_err_cnt};
      4'h4: rd_word[7:0] = rx_flags_q;
      4'h5: rd_word[2:0] = tx_flags_q;
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // AXI read handshake state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_q <= 1'b0;
      rresp_q <= RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      rdata_q <= rd_ok ? rd_word : 32'h0000_0000;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  // pin and protocol engine control
  assign can_tx = (running && joined_q) ? core_tx_bit : 1'b1;
  assign core_clk_en = running;
  assign core_halt = (mode == CPM_SOFT_RESET) || (mode == CPM_POWER_DOWN);
  assign core_joined = joined_q;
  assign core_copy_en = running;
  assign core_abort_en = running;
  assign core_tx_en = running && joined_q;
  assign core_recover_en = running;
  assign wakeup_irq = wakeup_irq_flag_q && wakeup_irq_enable_q && sleep_acknowledge_q;
  assign cpu_wake = (cpu_stop && rx_wake_dom) || (cpu_wait && core_irq) || (cpu_wait && wakeup_irq);
  assign timer_capture0 = (pulse_cnt_q != '0) && timer_link_enable_q;
  assign cfg_module_one = cfg_q[0];
  assign cfg_bit_timing = {cfg_q[2], cfg_q[1]};
  assign cfg_accept_ctrl = cfg_q[3];
  assign cfg_accept_codes = {cfg_q[7], cfg_q[6], cfg_q[5], cfg_q[4]};
  assign cfg_accept_masks = {cfg_q[11], cfg_q[10], cfg_q[9], cfg_q[8]};
  assign receiver_flags = rx_flags_q;
  assign transmit_empty_flag = tx_flags_q;
endmodule // cpm_top

// *** verif/cpm_asserts.sv ***
`timescale 1ns/1ps
module cpm_asserts import cpm_pkg::*; #(
  parameter int BIT_CYCLES = BIT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic can_tx,
  input wire logic cpu_stop,
  input wire logic cpu_wait,
  input wire logic cpu_wake,
  input wire logic core_irq,
  input wire logic core_bit_tick,
  input wire logic core_frame_ok,
  input wire logic [7:0] core_rx_flag_set,
  input wire logic core_clk_en,
  input wire logic core_halt,
  input wire logic core_joined,
  input wire logic core_copy_en,
  input wire logic core_abort_en,
  input wire logic core_tx_en,
  input wire logic core_recover_en,
  input wire logic [7:0] cfg_module_one,
  input wire logic [15:0] cfg_bit_timing,
  input wire logic [7:0] receiver_flags,
  input wire logic wakeup_irq,
  input wire logic timer_capture0
);
  logic [3:0] ticks_q;
  int hi_q;
  // bit ticks since the engine last entered normal mode, saturating
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ticks_q <= 4'h0;
    else if (!core_clk_en) ticks_q <= 4'h0;
    else if (core_bit_tick && ticks_q != 4'hf) ticks_q <= ticks_q + 4'h1;
  end
  // length of the running timer pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) hi_q <= 0;
    else hi_q <= timer_capture0 ? hi_q + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_tx_recessive: assert property (!core_clk_en |-> can_tx)
    else $error("tx pin driven outside normal mode");
  chk_stop_halt: assert property (cpu_stop |-> core_halt && !core_clk_en)
    else $error("cpu stop without power-down");
  chk_wake_irq: assert property (wakeup_irq |-> !core_clk_en)
    else $error("wakeup interrupt in normal mode");
  chk_action_gate: assert property (core_copy_en == core_clk_en && core_abort_en == core_clk_en
    && core_recover_en == core_clk_en) else $error("deferred actions not tied to normal mode");
  chk_tx_joined: assert property (core_tx_en |-> core_joined && core_clk_en)
    else $error("transmit enabled before joining");
  chk_join_wait: assert property ($rose(core_joined) |-> ticks_q >= RESYNC_BITS)
    else $error("joined before eleven bit times");
  chk_pulse_cause: assert property ($rose(timer_capture0) |-> $past(core_frame_ok))
    else $error("timer pulse without frame end");
  chk_pulse_len: assert property ($fell(timer_capture0) |-> hi_q == BIT_CYCLES)
    else $error("timer pulse not one bit long");
  chk_cfg_lock: assert property ($changed(cfg_bit_timing) || $changed(cfg_module_one)
    |-> $past(core_halt) && !$past(cpu_stop)) else $error("config changed outside soft reset");
  chk_wait_wake: assert property (cpu_wait && core_irq |-> cpu_wake)
    else $error("enabled interrupt did not end cpu wait");
  chk_flag_hold: assert property ($fell(receiver_flags[0]) |-> !$past(core_rx_flag_set[0]))
    else $error("flag cleared while its cause persists");
  cov_pulse: cover property ($rose(timer_capture0));
  cov_join: cover property ($rose(core_joined));
  cov_stop_wake: cover property (cpu_stop && cpu_wake);
  cov_wait_wake: cover property (cpu_wait && cpu_wake);
endmodule // cpm_asserts

bind cpm_top cpm_asserts #(.BIT_CYCLES(BIT_CYCLES)) chk_u (.clk, .arst_n, .can_tx, .cpu_stop, .cpu_wait,
  .cpu_wake, .core_irq, .core_bit_tick, .core_frame_ok, .core_rx_flag_set, .core_clk_en, .core_halt,
  .core_joined, .core_copy_en, .core_abort_en, .core_tx_en, .core_recover_en, .cfg_module_one,
  .cfg_bit_timing, .receiver_flags, .wakeup_irq, .timer_capture0);

// *** verif/cpm_bus_model.sv ***
`timescale 1ns/1ps
module cpm_bus_model import cpm_pkg::*; #(
  parameter int BIT_CYCLES = 4
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic can_tx,
  input wire logic core_clk_en,
  output logic can_rx,
  output logic core_bit_tick,
  output logic core_frame_ok,
  output logic core_rx_busy
);
  logic remote_q = 1'b1;
  int div_q;
  // wired-and bus, recessive whenever nobody pulls it dominant
  assign can_rx = remote_q & can_tx;
  // engine bit clock, stands still outside normal mode
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) div_q <= 0;
    else div_q <= (div_q == BIT_CYCLES - 1) ? 0 : div_q + 1;
  end
  assign core_bit_tick = core_clk_en && div_q == BIT_CYCLES - 1;
  initial begin
    core_frame_ok = 1'b0;
    core_rx_busy = 1'b0;
  end
  // remote frame; the engine only reports it if it ran through the whole frame
  task automatic recv_frame(input int bits);
    logic whole;
    whole = 1'b1;
    core_rx_busy <= 1'b1;
    for (int i = 0; i < bits; i++) begin
      remote_q <= i[0];
      repeat (BIT_CYCLES) @(posedge clk);
      whole = whole & core_clk_en;
    end
    remote_q <= 1'b1;
    core_rx_busy <= 1'b0;
    core_frame_ok <= whole;
    @(posedge clk);
    core_frame_ok <= 1'b0;
  endtask
  // dominant level for n clock cycles
  task automatic dominant(input int n);
    remote_q <= 1'b0;
    repeat (n) @(posedge clk);
    remote_q <= 1'b1;
  endtask
endmodule // cpm_bus_model

// *** verif/can_power_mode_and_protection_test.sv ***
`timescale 1ns/1ps
module can_power_mode_and_protection_test import cpm_pkg::*;;
  localparam int BC = 4;
  logic clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, can_rx, can_tx, cpu_stop, cpu_wait, cpu_wake;
  logic core_tx_bit, core_rx_busy, core_tx_busy, core_tx_pending, core_bit_tick, core_frame_ok, core_irq;
  logic core_clk_en, core_halt, core_joined, core_copy_en, core_abort_en, core_tx_en, core_recover_en;
  logic wakeup_irq, timer_capture0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, core_rx_err_cnt, core_tx_err_cnt, core_rx_flag_set;
  logic [7:0] cfg_module_one, cfg_accept_ctrl, receiver_flags;
  logic [31:0] s_axi_wdata, s_axi_rdata, cfg_accept_codes, cfg_accept_masks, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] core_tx_empty_set, transmit_empty_flag;
  logic [15:0] cfg_bit_timing;
  int error_cnt = 0, n_compared = 0, pulse_cnt = 0, wake_cnt = 0, p;

  cpm_top #(.BIT_CYCLES(BC), .FILT_CYCLES(3)) dut_u (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .can_rx, .can_tx, .cpu_stop, .cpu_wait, .cpu_wake, .core_tx_bit, .core_rx_busy,
    .core_tx_busy, .core_tx_pending, .core_bit_tick, .core_frame_ok, .core_irq, .core_rx_err_cnt,
    .core_tx_err_cnt, .core_rx_flag_set, .core_tx_empty_set, .core_clk_en, .core_halt, .core_joined,
    .core_copy_en, .core_abort_en, .core_tx_en, .core_recover_en, .cfg_module_one, .cfg_bit_timing,
    .cfg_accept_ctrl, .cfg_accept_codes, .cfg_accept_masks, .receiver_flags, .transmit_empty_flag,
    .wakeup_irq, .timer_capture0);
  cpm_bus_model #(.BIT_CYCLES(BC)) bus_u (.clk, .arst_n, .can_tx, .core_clk_en, .can_rx, .core_bit_tick,
    .core_frame_ok, .core_rx_busy);

  // clock and the pulse and wake monitors
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (timer_capture0 === 1'b1) pulse_cnt++;
    if (cpu_wake === 1'b1) wake_cnt++;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // control word with the joined bit masked off
  task automatic ctrl_chk(input string what, input logic [31:0] exp);
    axi_read(OFS_CTRL0);
    check(what, rd & 32'hbf, exp);
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    complete_run();
  end
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0000, 32'h0, 4'h1};
    {cpu_stop, cpu_wait, core_tx_bit, core_tx_busy, core_tx_pending, core_irq} = 6'h08;
    {core_rx_err_cnt, core_tx_err_cnt, core_rx_flag_set, core_tx_empty_set} = {8'h12, 8'h34, 8'h00, 3'h0};
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    ctrl_chk("ctrl after reset", 32'h1);
    check("tx in soft reset", can_tx, 32'h1);
    for (int i = 0; i < CFG_WORDS; i++) axi_write(OFS_CFG_FIRST + 8'(4 * i), 32'(17 * i + 1));
    for (int i = 0; i < CFG_WORDS; i++) begin
      axi_read(OFS_CFG_FIRST + 8'(4 * i));
      check("config word", rd, 32'(17 * i + 1));
    end
    check("mask words", cfg_accept_masks, 32'hbcab9a89);
    axi_write(OFS_ERR_CNT, 32'hffff);
    axi_read(OFS_ERR_CNT);
    check("error counters", rd, 32'h3412);
    axi_read(8'h40);
    check("unmapped response", rsp, RESP_SLVERR);
    axi_write(OFS_CTRL0, 32'h8);
    check("tx gated before join", core_tx_en, 32'h0);
    for (int i = 0; i < 200 && core_joined !== 1'b1; i++) @(posedge clk);
    axi_read(OFS_CTRL0);
    check("joined normal", rd, 32'h48);
    axi_write(OFS_CFG_FIRST, 32'h0);
    axi_read(OFS_CFG_FIRST);
    check("locked config", rd, 32'h1);
    core_tx_bit <= 1'b0;
    @(posedge clk);
    check("tx follows engine", can_tx, 32'h0);
    core_tx_bit <= 1'b1;
    p = pulse_cnt;
    bus_u.recv_frame(6);
    repeat (BC + 3) @(posedge clk);
    check("pulse length", pulse_cnt - p, BC);
    axi_write(OFS_CTRL0, 32'h0);
    p = pulse_cnt;
    bus_u.recv_frame(6);
    repeat (BC + 3) @(posedge clk);
    check("pulse gated", pulse_cnt - p, 32'h0);
    {core_tx_busy, core_tx_pending} <= 2'b11;
    axi_write(OFS_CTRL0, 32'h12);
    ctrl_chk("sleep held by queue", 32'h12);
    axi_write(OFS_CTRL0, 32'h10);
    ctrl_chk("early clear refused", 32'h12);
    {core_tx_busy, core_tx_pending} <= 2'b00;
    repeat (3) @(posedge clk);
    ctrl_chk("asleep", 32'h16);
    check("sleep state", {can_tx, core_clk_en, core_copy_en}, 32'h4);
    core_rx_flag_set <= 8'h01;
    axi_write(OFS_RX_FLAGS, 32'h1);
    axi_read(OFS_RX_FLAGS);
    check("flag held by cause", rd, 32'h1);
    core_rx_flag_set <= 8'h00;
    axi_write(OFS_RX_FLAGS, 32'h1);
    axi_read(OFS_RX_FLAGS);
    check("flag cleared asleep", rd, 32'h0);
    core_tx_empty_set <= 3'h5;
    @(posedge clk);
    core_tx_empty_set <= 3'h0;
    axi_write(OFS_TX_FLAGS, 32'h1);
    axi_read(OFS_TX_FLAGS);
    check("tx flags", {transmit_empty_flag, rd[2:0]}, 32'h24);
    bus_u.dominant(1);
    repeat (8) @(posedge clk);
    ctrl_chk("glitch filtered", 32'h16);
    bus_u.recv_frame(6);
    ctrl_chk("bus wakeup", 32'h30);
    check("wakeup irq awake", wakeup_irq, 32'h0);
    axi_write(OFS_CTRL0, 32'h20);
    ctrl_chk("wakeup flag cleared", 32'h0);
    axi_write(OFS_CTRL0, 32'h2);
    ctrl_chk("idle sleep", 32'h6);
    axi_write(OFS_CTRL0, 32'h0);
    ctrl_chk("wake by clear", 32'h0);
    axi_write(OFS_CTRL0, 32'h2);
    axi_write(OFS_CTRL0, 32'h3);
    axi_read(OFS_CTRL0);
    check("wake by soft reset", rd & 32'hbd, 32'h1);
    check("halted", {core_halt, can_tx}, 32'h3);
    cpu_stop <= 1'b1;
    axi_read(OFS_CTRL0);
    check("access in power-down", rsp, RESP_SLVERR);
    p = wake_cnt;
    bus_u.dominant(8);
    check("cpu woken by bus", wake_cnt > p, 32'h1);
    cpu_stop <= 1'b0;
    cpu_wait <= 1'b1;
    core_irq <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check("wait ended by irq", cpu_wake, 32'h1);
    core_irq <= 1'b0;
    cpu_wait <= 1'b0;
    complete_run();
  end
endmodule // can_power_mode_and_protection_test
